// >>> e3_rx_overhead_map.vh
`ifndef E3_RX_OVERHEAD_MAP_VH
`define E3_RX_OVERHEAD_MAP_VH

// Overhead bits carried by one E3 frame
`define OH_BITS_PER_FRAME 56
`define OH_LAST_BIT_INDEX 6'h37
`define OH_FIRST_BIT_INDEX 6'h00
`define OH_COUNT_WIDTH 6

// Output clock periods spent on each overhead bit
`define OH_PERIODS_PER_BIT 8
`define OH_PHASE_WIDTH 4

// E3 line rate of the output clock, in kHz
`define E3_LINE_RATE_KHZ 34368

// Sequencer states
`define OH_ST_IDLE 1'b0
`define OH_ST_SHIFT 1'b1

// Entry of the staging FIFO: {first bit of frame, bit value}
`define OH_ENTRY_WIDTH 2
`define OH_ENTRY_FIRST 1
`define OH_ENTRY_DATA 0
`define OH_FIFO_DEPTH 8

// Synchronised pins and their slots in the pin vector
`define OH_SYNC_PINS 3
`define OH_PIN_LINE 0
`define OH_PIN_LOCAL 1
`define OH_PIN_LOOP 2

`endif

// >>> oh_bit_fifo.v
`timescale 1ns/100ps
`default_nettype none

module oh_bit_fifo #(
	parameter WIDTH = 2,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// Fill side
	input wire i_in_valid,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_in_ready,
	// Drain side
	output wire o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input wire i_out_ready
);

	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	reg [AW:0] nxt_count;
	reg in_ready_ff;
	wire push;
	wire pop;

	// Handshakes on both sides; ready comes from a flop
	assign o_in_ready = in_ready_ff;
	assign o_out_valid = (count_ff != {(AW+1){1'b0}});
	assign o_out_data = mem_ff[rd_ptr_ff];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// Storage write
	always @(posedge i_clk_sys)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= i_in_data;
	end

	// Fill level after this cycle's push and pop
	always @*
	begin
		nxt_count = count_ff;
		if (push && !pop)
			nxt_count = count_ff + 1'b1;
		else if (pop && !push)
			nxt_count = count_ff - 1'b1;
	end

	// Pointers and fill level
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
			in_ready_ff <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
			count_ff <= nxt_count;
			in_ready_ff <= (nxt_count != DEPTH[AW:0]); // Full when every slot is held
		end
	end

endmodule // oh_bit_fifo

`default_nettype wire

// >>> e3_rx_overhead_enable_port.v
// Contract
// - Each overhead bit of an inbound frame is shown one at a time on the overhead data output.
// - Every bit gets one enable pulse, one output clock period long, near the middle of the bit.
// - Frame start stays high for the whole time the first overhead bit of a frame is shown.
// - The output clock follows the line receive clock in loop timing, else the local clock.
// - In E3 operation the output clock runs at the E3 line rate of 34.368 MHz.
// - The pulse seen with frame start is count zero, the top bit of the first alignment byte.
// - Counts 0-55 map to FA1, FA2, EM, TR, MA, NR, GC bytes in order, each MSB first.
// - With a dedicated overhead clock, frame start lasts one such period and its edges count.
`timescale 1ns/100ps
`default_nettype none
`include "e3_rx_overhead_map.vh"

module e3_rx_overhead_enable_port #(
	parameter PERIODS_PER_BIT = `OH_PERIODS_PER_BIT,
	parameter FIFO_DEPTH = `OH_FIFO_DEPTH
) (
	// System clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// Clock pins and timing select
	input wire i_line_receive_clock,
	input wire i_local_transmit_input_clock,
	input wire i_loop_timing,
	// Overhead bits from the receive framer
	input wire i_oh_bit_valid,
	input wire i_oh_bit,
	input wire i_oh_bit_first,
	output wire o_oh_bit_ready,
	// Terminal side pins
	output reg o_rx_section_output_clock,
	output reg o_rx_overhead_data_out,
	output reg o_rx_overhead_sample_enable,
	output reg o_rx_overhead_frame_start
);

	// ----------------------------------------
	// Timing constants
	// ----------------------------------------
	localparam [`OH_PHASE_WIDTH-1:0] LAST_PHASE = PERIODS_PER_BIT[`OH_PHASE_WIDTH-1:0] - 1'b1;
	localparam [`OH_PHASE_WIDTH-1:0] MID_PHASE = PERIODS_PER_BIT[`OH_PHASE_WIDTH:1];
	localparam [`OH_COUNT_WIDTH-1:0] LAST_BIT = `OH_LAST_BIT_INDEX;
	localparam [`OH_COUNT_WIDTH-1:0] FIRST_BIT = `OH_FIRST_BIT_INDEX;
	localparam integer LINE_RATE_KHZ = `E3_LINE_RATE_KHZ;
	// FIFO pointer width follows its depth
	localparam integer FIFO_AW = $clog2(FIFO_DEPTH);
	// Sequencer state codes
	localparam [0:0] ST_IDLE = `OH_ST_IDLE;
	localparam [0:0] ST_SHIFT = `OH_ST_SHIFT;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [`OH_SYNC_PINS-1:0] pin_async;
	wire [`OH_SYNC_PINS-1:0] pin_sync;
	reg sel_clk_prev_ff;
	wire sel_clk;
	wire sel_rise;
	genvar g;

	// Pins gathered so one loop builds every synchroniser
	assign pin_async = {i_loop_timing, i_local_transmit_input_clock, i_line_receive_clock};

	// Two flops on every pin before any logic reads it
	generate
		for (g = 0; g < `OH_SYNC_PINS; g = g + 1)
		begin : g_sync
			reg meta_ff;
			reg sync_ff;
			always @(posedge i_clk_sys or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					meta_ff <= 1'b0;
					sync_ff <= 1'b0;
				end
				else
				begin
					meta_ff <= pin_async[g];
					sync_ff <= meta_ff;
				end
			end
			assign pin_sync[g] = sync_ff; // Only the second flop leaves
		end
	endgenerate

	// Last level of the chosen clock, for the edge finder
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			sel_clk_prev_ff <= 1'b0;
		else
			sel_clk_prev_ff <= sel_clk;
	end

	// Clock source choice and edge finder
	assign sel_clk = pin_sync[`OH_PIN_LOOP] ?
		pin_sync[`OH_PIN_LINE] : pin_sync[`OH_PIN_LOCAL];
	assign sel_rise = sel_clk & ~sel_clk_prev_ff;

	// ----------------------------------------
	// Staging FIFO
	// ----------------------------------------
	wire fifo_valid;
	wire [`OH_ENTRY_WIDTH-1:0] fifo_data;
	reg fifo_pop;

	oh_bit_fifo #(
		.WIDTH(`OH_ENTRY_WIDTH),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_in_valid(i_oh_bit_valid),
		.i_in_data({i_oh_bit_first, i_oh_bit}),
		.o_in_ready(o_oh_bit_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_pop)
	);

	// ----------------------------------------
	// Bit sequencer
	// ----------------------------------------
	reg state_ff;
	reg nxt_state;
	reg [`OH_PHASE_WIDTH-1:0] phase_ff;
	reg [`OH_PHASE_WIDTH-1:0] nxt_phase;
	reg [`OH_COUNT_WIDTH-1:0] bit_cnt_ff;
	reg [`OH_COUNT_WIDTH-1:0] nxt_bit_cnt;
	reg nxt_data;
	reg nxt_enable;
	reg nxt_frame;
	reg load;

	// Next-state logic, advanced only on output clock rises
	always @*
	begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_data = o_rx_overhead_data_out;
		nxt_enable = o_rx_overhead_sample_enable;
		nxt_frame = o_rx_overhead_frame_start;
		load = 1'b0;
		if (sel_rise)
		begin
			case (state_ff)
				ST_IDLE:
				begin
					nxt_enable = 1'b0;
					load = fifo_valid;
				end
				ST_SHIFT:
				begin
					nxt_phase = phase_ff + 1'b1;
					nxt_enable = (nxt_phase == MID_PHASE);
					if (phase_ff == LAST_PHASE)
					begin
						nxt_enable = 1'b0;
						load = fifo_valid;
						if (!fifo_valid)
						begin
							nxt_state = ST_IDLE;
							nxt_frame = 1'b0;
						end
					end
				end
				default:
				begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
		if (load)
		begin
			nxt_state = ST_SHIFT;
			nxt_phase = {`OH_PHASE_WIDTH{1'b0}};
			nxt_data = fifo_data[`OH_ENTRY_DATA];
			// Framer marker realigns; otherwise wrap after the last bit
			if (fifo_data[`OH_ENTRY_FIRST] || bit_cnt_ff == LAST_BIT)
				nxt_bit_cnt = FIRST_BIT;
			else
				// One count step per bit, as a dedicated bit clock would give
				nxt_bit_cnt = bit_cnt_ff + 1'b1;
			nxt_frame = (nxt_bit_cnt == FIRST_BIT);
			nxt_enable = (MID_PHASE == {`OH_PHASE_WIDTH{1'b0}});
		end
		fifo_pop = load;
	end

	// Sequencer and output registers
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_ff <= ST_IDLE;
			phase_ff <= {`OH_PHASE_WIDTH{1'b0}};
			bit_cnt_ff <= `OH_LAST_BIT_INDEX;
			o_rx_section_output_clock <= 1'b0;
			o_rx_overhead_data_out <= 1'b0;
			o_rx_overhead_sample_enable <= 1'b0;
			o_rx_overhead_frame_start <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			bit_cnt_ff <= nxt_bit_cnt;
			o_rx_section_output_clock <= sel_clk;
			o_rx_overhead_data_out <= nxt_data;
			o_rx_overhead_sample_enable <= nxt_enable;
			o_rx_overhead_frame_start <= nxt_frame;
		end
	end

endmodule // e3_rx_overhead_enable_port

`default_nettype wire

// >>> e3_rx_oh_port_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module e3_rx_oh_port_checker (
	// Clocks, select and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_line_receive_clock,
	input wire logic i_local_transmit_input_clock,
	input wire logic i_loop_timing,
	// Watched outputs
	input wire logic o_oh_bit_ready,
	input wire logic o_rx_section_output_clock,
	input wire logic o_rx_overhead_data_out,
	input wire logic o_rx_overhead_sample_enable,
	input wire logic o_rx_overhead_frame_start
);
	wire ck = o_rx_section_output_clock;
	wire dq = o_rx_overhead_data_out;
	wire en = o_rx_overhead_sample_enable;
	wire fs = o_rx_overhead_frame_start;
	logic [2:0] age_ff;
	// Cycles since release, so clock delays are not judged on reset values
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
			age_ff <= 3'h0;
		else if (age_ff != 3'h7)
			age_ff <= age_ff + 3'h1;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	AST_DATA_AT_RISE: assert property ($changed(dq) |-> $rose(ck))
		else $error("data moved off an output clock rise");
	AST_EN_AT_RISE: assert property ($changed(en) |-> $rose(ck))
		else $error("enable moved off an output clock rise");
	AST_EN_ONE_PERIOD: assert property ($rose(ck) && $past(en) |-> !en)
		else $error("enable longer than one period");
	AST_EN_MID_BIT: assert property (en |-> $stable(dq) && $stable(fs))
		else $error("enable at a bit boundary");
	AST_FS_AT_RISE: assert property ($changed(fs) |-> $rose(ck))
		else $error("frame start moved off a rise");
	AST_FS_SPANS_PULSE: assert property ($rose(fs) |-> fs throughout ##[1:900] $rose(en))
		else $error("frame start ended before its enable");
	AST_LOOP_SRC: assert property (age_ff == 3'h7 && i_loop_timing && $past(i_loop_timing, 5)
		|-> ck == $past(i_line_receive_clock, 3))
		else $error("output clock not the line clock");
	AST_LOCAL_SRC: assert property (age_ff == 3'h7 && !i_loop_timing && !$past(i_loop_timing, 5)
		|-> ck == $past(i_local_transmit_input_clock, 3))
		else $error("output clock not the local clock");
	COV_FRAME_PULSE: cover property (fs && $rose(en));
	COV_LOCAL_PULSE: cover property (!i_loop_timing && $rose(en));
	COV_FULL: cover property (!o_oh_bit_ready);
endmodule // e3_rx_oh_port_checker
bind e3_rx_overhead_enable_port e3_rx_oh_port_checker u_chk (
	.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n),
	.i_line_receive_clock(i_line_receive_clock),
	.i_local_transmit_input_clock(i_local_transmit_input_clock),
	.i_loop_timing(i_loop_timing),
	.o_oh_bit_ready(o_oh_bit_ready),
	.o_rx_section_output_clock(o_rx_section_output_clock),
	.o_rx_overhead_data_out(o_rx_overhead_data_out),
	.o_rx_overhead_sample_enable(o_rx_overhead_sample_enable),
	.o_rx_overhead_frame_start(o_rx_overhead_frame_start)
);
`default_nettype wire

// >>> oh_terminal_model.sv
`timescale 1ns/100ps
`default_nettype none
module oh_terminal_model (
	// Terminal side pins
	input wire logic i_clk,
	input wire logic i_en,
	input wire logic i_fs,
	input wire logic i_data,
	// Collected frame
	output logic [55:0] o_frame,
	output logic [5:0] o_count,
	output int o_frames,
	output int o_pulses
);
	initial
	begin
		o_count = 6'h37;
		o_frames = 0;
		o_pulses = 0;
	end
	// Capture on falling edges only when enable is seen high
	always @(negedge i_clk)
		if (i_en === 1'b1)
		begin
			o_pulses = o_pulses + 1;
			o_count = (i_fs === 1'b1) ? 6'h00 : o_count + 6'h01;
			o_frame[6'h37 - o_count] = i_data;
			if (o_count == 6'h37)
				o_frames = o_frames + 1;
		end
endmodule // oh_terminal_model
`default_nettype wire

// >>> e3_rx_overhead_enable_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin check_count++; if ((sn) !== (ex)) begin fail_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, sn); end end
module e3_rx_overhead_enable_port_tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, line_clk = 1'b0, loc_clk = 1'b0, loop_t = 1'b1;
	logic bit_valid = 1'b0, oh_bit = 1'b0, bit_first = 1'b0, refused;
	wire bit_ready, out_clk, oh_data, oh_en, oh_fs;
	wire [55:0] got_frame;
	wire [5:0] got_cnt;
	int frames, pulses, fail_count = 0, check_count = 0;
	// ----------------------------------------
	// Clocks; each link clock runs only when selected
	// ----------------------------------------
	always #2.5 clk_sys = ~clk_sys;
	initial begin #1.3; forever #80 if (loop_t) line_clk = ~line_clk; end
	initial begin #2.1; forever #80 if (!loop_t) loc_clk = ~loc_clk; end
	e3_rx_overhead_enable_port uut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_line_receive_clock(line_clk), .i_local_transmit_input_clock(loc_clk),
		.i_loop_timing(loop_t), .i_oh_bit_valid(bit_valid), .i_oh_bit(oh_bit),
		.i_oh_bit_first(bit_first), .o_oh_bit_ready(bit_ready),
		.o_rx_section_output_clock(out_clk), .o_rx_overhead_data_out(oh_data),
		.o_rx_overhead_sample_enable(oh_en), .o_rx_overhead_frame_start(oh_fs));
	oh_terminal_model term (.i_clk(out_clk), .i_en(oh_en), .i_fs(oh_fs), .i_data(oh_data),
		.o_frame(got_frame), .o_count(got_cnt), .o_frames(frames), .o_pulses(pulses));
	// Offer a frame MSB first, holding each bit while the FIFO refuses
	task push_frame(input logic [55:0] pat, input logic flag, input int nbits = 56);
		refused = 1'b0;
		for (int i = 55; i > 55 - nbits; i--)
		begin
			bit_valid = 1'b1;
			oh_bit = pat[i];
			bit_first = flag && (i == 55);
			while (bit_ready !== 1'b1)
			begin
				refused = 1'b1;
				@(negedge clk_sys);
			end
			@(negedge clk_sys);
		end
		bit_valid = 1'b0;
	endtask
	task wait_frames(input int n);
		for (int k = 0; k < 40000 && frames < n; k++)
			@(negedge clk_sys);
	endtask
	// Loop timing, flagged frame, FIFO filled to refusal
	task t_loop_frame;
		push_frame(56'h1b3c_a596_0f78_e2, 1'b1);
		`CHK("fifo refusal", 1'b1, refused)
		wait_frames(1);
		`CHK("frames", 1, frames)
		`CHK("frame bits", 56'h1b3c_a596_0f78_e2, got_frame)
		`CHK("last count", 6'h37, got_cnt)
	endtask
	// Local timing, unflagged frame must restart at zero, then drain
	task t_local_wrap;
		loop_t = 1'b0;
		push_frame(56'he4c3_5a69_f087_1d, 1'b0);
		wait_frames(2);
		`CHK("frame bits", 56'he4c3_5a69_f087_1d, got_frame)
		repeat (600) @(negedge clk_sys);
		`CHK("pulses", 112, pulses)
		`CHK("idle enable", 1'b0, oh_en)
		`CHK("ready after drain", 1'b1, bit_ready)
	endtask
	// Stray bits, then a flagged frame must pull the count back to zero
	task t_realign;
		push_frame(56'h0000_0000_0000_00, 1'b0, 3);
		@(negedge clk_sys);
		push_frame(56'h6d29_c4b0_5e13_87, 1'b1);
		wait_frames(3);
		`CHK("realigned frames", 3, frames)
		`CHK("realigned bits", 56'h6d29_c4b0_5e13_87, got_frame)
		`CHK("pulses after realign", 171, pulses)
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		t_loop_frame;
		t_local_wrap;
		t_realign;
		final_report;
	end
	// Watchdog
	initial
	begin
		#400000;
		fail_count++;
		final_report;
	end
endmodule // e3_rx_overhead_enable_port_tb_top
`default_nettype wire
